// [vtd_dispatch.v]
`timescale 1ns/1ns
`include "vtd_defines.vh"

// Contract
// - Vector segment comes from segment register.
// - Spacing field sets distance between vectors.
// - Spacing resets to four bytes.
// - Hardware trap offers ignore every enable and mask; mask_r gates irq_o.
// - Trap branches to its own vector; the class B traps share one.
// - Each trap sets its own flag bit.
// - Trap preempts unless same or higher trap running.
// - Trap service blocks interrupts and transfers.
// - Subchannel end node uses trap 4C.
// - Node register holds request, enable, priority.
// - Only strictly higher priority preempts service.
// - Software request bit acts like hardware.
module vtd_dispatch (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire [7:0] trap_i,
	input wire [7:0] node_req_i,
	input wire vec_ack_i,
	input wire svc_done_i,
	output reg vec_valid_o,
	output reg [23:0] vec_addr_o,
	output reg [6:0] vec_trap_num_o,
	output reg vec_is_trap_o,
	output wire etc_allow_o,
	output wire irq_o
);

	localparam DEPTH = 8;

	reg [7:0] vector_segment_register_r;
	reg [1:0] vector_spacing_field_r;
	reg [7:0] trap_flag_register_r;
	reg [7:0] mask_r;
	reg [7:0] node_ctl_r [0:7];
	reg [7:0] trap_pend_r;
	reg ctx_trap_r;
	reg [3:0] ctx_lvl_r;
	reg [4:0] stk_r [0:DEPTH-1];
	reg [3:0] sp_r;
	reg off_trap_r;
	reg [2:0] off_idx_r;
	reg [3:0] off_lvl_r;
	reg [7:0] wr_tfr_clr;
	reg [7:0] ack_node_clr;
	reg [7:0] ack_trap_clr;
	reg sel_valid;
	reg sel_trap;
	reg [2:0] sel_idx;
	reg [3:0] sel_lvl;
	reg [6:0] sel_num;
	reg [2:0] spc_shift;
	reg [15:0] sel_off;
	reg [31:0] rd_data;
	integer i;
	integer j;
	integer k;
	integer m;
	integer n;

	wire bus_req;
	wire bus_wr;
	wire accept;

	// Trap number of each node, fixed by its wiring.
	function [6:0] node_trap;
		input [2:0] idx;
		begin
			case (idx)
				3'h0: node_trap = `VTD_NODE_TRAP0;
				3'h1: node_trap = `VTD_NODE_TRAP1;
				3'h2: node_trap = `VTD_NODE_TRAP2;
				3'h3: node_trap = `VTD_NODE_TRAP3;
				3'h4: node_trap = `VTD_NODE_TRAP4;
				3'h5: node_trap = `VTD_NODE_TRAP5;
				3'h6: node_trap = `VTD_NODE_TRAP6;
				3'h7: node_trap = `VTD_NODE_TRAP7;
				default: node_trap = `VTD_NODE_TRAP0;
			endcase
		end
	endfunction

	// Trap number of each hardware trap; the four class B traps share one.
	function [6:0] hw_trap;
		input [2:0] idx;
		begin
			case (idx)
				3'h0: hw_trap = `VTD_TRAP_NMI;
				3'h1: hw_trap = `VTD_TRAP_STKOF;
				3'h2: hw_trap = `VTD_TRAP_STKUF;
				3'h3: hw_trap = `VTD_TRAP_BRK;
				default: hw_trap = `VTD_TRAP_CLSB;
			endcase
		end
	endfunction

	// A single cycle slave: one wait state, then ack for one cycle.
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	assign accept = vec_valid_o & vec_ack_i;

	// transfers are held off during a trap service.
	assign etc_allow_o = ~ctx_trap_r;

	// Interrupt line follows the unmasked trap flags.
	assign irq_o = |(trap_flag_register_r & mask_r);

	// Selection of the next vector to offer, traps first.
	always @*
	begin
		sel_valid = 1'b0;
		sel_trap = 1'b0;
		sel_idx = 3'h0;
		sel_lvl = 4'h0;
		// nodes must beat the running level strictly
		for (i = 7; i >= 0; i = i - 1)
		begin
			if (node_ctl_r[i][`VTD_NODE_REQ_BIT] && node_ctl_r[i][`VTD_NODE_ENA_BIT] &&
				(node_ctl_r[i][`VTD_NODE_LVL_MSB:0] > ctx_lvl_r) &&
				(!sel_valid || node_ctl_r[i][`VTD_NODE_LVL_MSB:0] > sel_lvl))
			begin
				sel_valid = 1'b1;
				sel_idx = i[2:0];
				sel_lvl = node_ctl_r[i][`VTD_NODE_LVL_MSB:0];
			end
		end
		// no standard request during a trap service
		if (ctx_trap_r)
			sel_valid = 1'b0;
		for (j = 7; j >= 0; j = j - 1)
		begin
			// only the same or a higher running trap holds it off
			if (trap_pend_r[j] && (!ctx_trap_r || j[3:0] < ctx_lvl_r))
			begin
				sel_valid = 1'b1;
				sel_trap = 1'b1;
				sel_idx = j[2:0];
				sel_lvl = j[3:0];
			end
		end
	end

	// Vector address formed from segment, trap number and spacing.
	always @*
	begin
		sel_num = sel_trap ? hw_trap(sel_idx) : node_trap(sel_idx);
		spc_shift = `VTD_SPC_BASE_SHIFT + {1'b0, vector_spacing_field_r};
		// offset is trap number times spacing
		sel_off = {9'h000, sel_num} << spc_shift;
	end

	// Offer register toward the CPU core, refreshed until taken.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			vec_valid_o <= 1'b0;
			vec_addr_o <= 24'h000000;
			vec_trap_num_o <= 7'h00;
			vec_is_trap_o <= 1'b0;
			off_trap_r <= 1'b0;
			off_idx_r <= 3'h0;
			off_lvl_r <= 4'h0;
		end
		else if (accept)
			vec_valid_o <= 1'b0;
		else
		begin
			vec_valid_o <= sel_valid;
			// segment register gives the upper address
			vec_addr_o <= {vector_segment_register_r, sel_off};
			vec_trap_num_o <= sel_num;
			// trap offered like an interrupt entry
			vec_is_trap_o <= sel_trap;
			off_trap_r <= sel_trap;
			off_idx_r <= sel_idx;
			off_lvl_r <= sel_lvl;
		end
	end

	// Clear masks produced by bus writes and by accepted entries.
	always @*
	begin
		wr_tfr_clr = 8'h00;
		ack_node_clr = 8'h00;
		ack_trap_clr = 8'h00;
		if (bus_wr && wb_adr_i == `VTD_OFF_TFR)
			wr_tfr_clr = wb_dat_i[7:0];
		if (accept && !off_trap_r)
			ack_node_clr[off_idx_r] = 1'b1;
		if (accept && off_trap_r)
			ack_trap_clr[off_idx_r] = 1'b1;
	end

	// Context and nesting stack of running services.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctx_trap_r <= 1'b0;
			ctx_lvl_r <= 4'h0;
			sp_r <= 4'h0;
			for (k = 0; k < DEPTH; k = k + 1)
				stk_r[k] <= 5'h00;
		end
		else if (accept)
		begin
			if (sp_r < DEPTH)
			begin
				stk_r[sp_r[2:0]] <= {ctx_trap_r, ctx_lvl_r};
				sp_r <= sp_r + 4'h1;
			end
			ctx_trap_r <= off_trap_r;
			ctx_lvl_r <= off_lvl_r;
		end
		else if (svc_done_i && sp_r != 4'h0)
		begin
			ctx_trap_r <= stk_r[sp_r[2:0] - 3'h1][4];
			ctx_lvl_r <= stk_r[sp_r[2:0] - 3'h1][3:0];
			sp_r <= sp_r - 4'h1;
		end
		else if (svc_done_i)
		begin
			ctx_trap_r <= 1'b0;
			ctx_lvl_r <= 4'h0;
		end
	end

	// Trap flags and pending traps; a new event wins over a clear.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			trap_flag_register_r <= 8'h00;
			trap_pend_r <= 8'h00;
		end
		else
		begin
			// flags clear only on a software write of one; pending traps clear on accept
			trap_flag_register_r <= (trap_flag_register_r & ~wr_tfr_clr) | trap_i;
			trap_pend_r <= (trap_pend_r & ~ack_trap_clr) | trap_i;
		end
	end

	// Node control registers, configuration and bus writes.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			vector_segment_register_r <= `VTD_RST_SEG;
			vector_spacing_field_r <= `VTD_RST_SPC;
			mask_r <= `VTD_RST_MASK;
			for (m = 0; m < 8; m = m + 1)
				node_ctl_r[m] <= `VTD_RST_NODE;
		end
		else
		begin
			if (bus_wr && wb_adr_i == `VTD_OFF_SEG)
				vector_segment_register_r <= wb_dat_i[7:0];
			if (bus_wr && wb_adr_i == `VTD_OFF_CON1)
				vector_spacing_field_r <= wb_dat_i[1:0];
			if (bus_wr && wb_adr_i == `VTD_OFF_MASK)
				mask_r <= wb_dat_i[7:0];
			for (m = 0; m < 8; m = m + 1)
			begin
				// request, enable and level per node
				// software set raises a request too
				if (bus_wr && wb_adr_i == `VTD_OFF_NODE0 + {m[5:0], 2'h0})
					node_ctl_r[m] <= wb_dat_i[7:0];
				else if (ack_node_clr[m])
					node_ctl_r[m][`VTD_NODE_REQ_BIT] <= 1'b0;
				if (node_req_i[m])
					node_ctl_r[m][`VTD_NODE_REQ_BIT] <= 1'b1;
			end
		end
	end

	// Read data selection; unmapped offsets read as zero.
	always @*
	begin
		rd_data = 32'h00000000;
		case (wb_adr_i)
			`VTD_OFF_SEG: rd_data[7:0] = vector_segment_register_r;
			`VTD_OFF_CON1: rd_data[1:0] = vector_spacing_field_r;
			`VTD_OFF_TFR: rd_data[7:0] = trap_flag_register_r;
			`VTD_OFF_MASK: rd_data[7:0] = mask_r;
			`VTD_OFF_STATE: rd_data[8:0] = {sp_r, ctx_trap_r, ctx_lvl_r};
			default:
			begin
				for (n = 0; n < 8; n = n + 1)
					if (wb_adr_i == `VTD_OFF_NODE0 + {n[5:0], 2'h0})
						rd_data[7:0] = node_ctl_r[n];
			end
		endcase
	end

	// Bus answer registers.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_data : 32'h00000000;
		end
	end

endmodule

// [vtd_defines.vh]
`ifndef VTD_DEFINES_VH
`define VTD_DEFINES_VH

// Register byte offsets on the Wishbone bus.
`define VTD_OFF_SEG 8'h00
`define VTD_OFF_CON1 8'h04
`define VTD_OFF_TFR 8'h08
`define VTD_OFF_MASK 8'h0C
`define VTD_OFF_STATE 8'h10
`define VTD_OFF_NODE0 8'h20

// Reset values.
`define VTD_RST_SEG 8'h00
`define VTD_RST_SPC 2'h0
`define VTD_RST_MASK 8'h00
`define VTD_RST_NODE 8'h00

// Field positions in a node control register.
`define VTD_NODE_LVL_MSB 3
`define VTD_NODE_ENA_BIT 6
`define VTD_NODE_REQ_BIT 7

// Spacing field code 0 gives 4 bytes; each step doubles it.
`define VTD_SPC_BASE_SHIFT 3'h2

// Trap numbers of the hardware traps.
`define VTD_TRAP_NMI 7'h02
`define VTD_TRAP_STKOF 7'h04
`define VTD_TRAP_STKUF 7'h06
`define VTD_TRAP_BRK 7'h08
`define VTD_TRAP_CLSB 7'h0A

// Trap numbers of the interrupt nodes.
`define VTD_NODE_TRAP0 7'h10
`define VTD_NODE_TRAP1 7'h20
`define VTD_NODE_TRAP2 7'h28
`define VTD_NODE_TRAP3 7'h2B
`define VTD_NODE_TRAP4 7'h40
`define VTD_NODE_TRAP5 7'h41
`define VTD_NODE_TRAP6 7'h4B
`define VTD_NODE_TRAP7 7'h4C

`endif

// [vtd_monitor.sv]
`timescale 1ns/1ns
// Watches the bus and vector ports of the dispatcher.
module vtd_monitor (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire wb_ack_o,
	input wire [7:0] trap_i,
	input wire vec_ack_i,
	input wire svc_done_i,
	input wire vec_valid_o,
	input wire [23:0] vec_addr_o,
	input wire [6:0] vec_trap_num_o,
	input wire vec_is_trap_o,
	input wire etc_allow_o,
	input wire irq_o
);
	reg [7:0] seg_r;
	reg [1:0] spc_r;
	wire wr_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
	// Shadow segment and spacing, updated at the edge a write is taken.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			seg_r <= 8'h00;
			spc_r <= 2'h0;
		end
		else if (wr_take && wb_adr_i == 8'h00)
			seg_r <= wb_dat_i[7:0];
		else if (wr_take && wb_adr_i == 8'h04)
			spc_r <= wb_dat_i[1:0];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Bus ack too long.");
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Bus ack late.");
	vector_address_a: assert property (
		vec_valid_o && $stable(seg_r) && $stable(spc_r) |->
		vec_addr_o == {seg_r, {9'h000, vec_trap_num_o} << ({1'b0, spc_r} + 3'h2)})
		else $error("Vector address wrong.");
	nmi_offer_a: assert property (
		trap_i[0] && etc_allow_o && !(vec_valid_o && vec_ack_i) ##1
		!(vec_valid_o && vec_ack_i) |=>
		vec_valid_o && vec_is_trap_o && vec_trap_num_o == 7'h02)
		else $error("Trap not offered.");
	accept_drop_a: assert property (vec_valid_o && vec_ack_i |=> !vec_valid_o)
		else $error("Offer kept after accept.");
	trap_blocks_a: assert property (!etc_allow_o && vec_valid_o |-> vec_is_trap_o)
		else $error("Node offered in trap service.");
	trap_entry_a: assert property (
		$fell(etc_allow_o) |-> $past(vec_valid_o && vec_ack_i && vec_is_trap_o))
		else $error("Trap state without trap accept.");
	trap_exit_a: assert property ($rose(etc_allow_o) |-> $past(svc_done_i))
		else $error("Trap state left without return.");
	flags_sticky_a: assert property ($fell(irq_o) |-> wb_ack_o)
		else $error("Interrupt fell without write.");
endmodule
bind vtd_dispatch vtd_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .trap_i, .vec_ack_i, .svc_done_i,
	.vec_valid_o, .vec_addr_o, .vec_trap_num_o, .vec_is_trap_o, .etc_allow_o, .irq_o);

// [vtd_cpu_model.sv]
`timescale 1ns/1ns
// CPU side: accepts after delay_i offer cycles, returns every svc_len_i+1 cycles, 0 never.
module vtd_cpu_model (
	input wire clk_i,
	input wire rst_i,
	input wire vec_valid_i,
	input wire [3:0] delay_i,
	input wire [7:0] svc_len_i,
	output reg vec_ack_o,
	output reg svc_done_o
);
	reg [3:0] wait_r;
	reg [7:0] run_r;
	// Accept and return pulses last one cycle each.
	always @(posedge clk_i)
	begin
		vec_ack_o <= 1'b0;
		svc_done_o <= 1'b0;
		wait_r <= vec_valid_i && !vec_ack_o ? wait_r + 4'h1 : 4'h0;
		run_r <= run_r + 8'h01;
		if (rst_i)
			run_r <= 8'h00;
		else if (vec_valid_i && !vec_ack_o && wait_r >= delay_i)
		begin
			vec_ack_o <= 1'b1;
			run_r <= 8'h00;
		end
		else if (svc_len_i != 8'h00 && run_r >= svc_len_i)
		begin
			svc_done_o <= 1'b1;
			run_r <= 8'h00;
		end
	end
endmodule

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg req = 1'b0;
	reg we = 1'b0;
	reg [3:0] sel = 4'h0;
	reg [3:0] wsel = 4'hF;
	reg [7:0] adr = 8'h00;
	reg [31:0] dat = 32'h0;
	reg [7:0] trap = 8'h00;
	reg [7:0] nreq = 8'h00;
	reg [3:0] dly = 4'h3;
	reg [7:0] svc = 8'h00;
	reg [31:0] rd;
	reg [23:0] va;
	reg [6:0] vn;
	integer mismatches = 0;
	integer compares = 0;
	integer cycles = 0;
	wire [31:0] rdat;
	wire ack, vack, done, valid, is_trap, allow, irq;
	wire [23:0] vaddr;
	wire [6:0] vnum;
	vtd_dispatch dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .trap_i(trap), .node_req_i(nreq), .vec_ack_i(vack),
		.svc_done_i(done), .vec_valid_o(valid), .vec_addr_o(vaddr), .vec_trap_num_o(vnum),
		.vec_is_trap_o(is_trap), .etc_allow_o(allow), .irq_o(irq));
	vtd_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .vec_valid_i(valid), .delay_i(dly),
		.svc_len_i(svc), .vec_ack_o(vack), .svc_done_o(done));
	task end_sim;
		begin
			$display("compares %0d mismatches %0d", compares, mismatches);
			if (mismatches == 0 && compares > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			compares = compares + 1;
			if (g !== e)
			begin
				mismatches = mismatches + 1;
				$display("Error at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	// Classic single cycle; only the bench timeout ends the wait for ack.
	task wb(input w, input [7:0] a, input [31:0] d);
		begin
			we <= w;
			adr <= a;
			dat <= d;
			sel <= wsel;
			req <= 1'b1;
			@(posedge clk_i);
			while (ack !== 1'b1)
				@(posedge clk_i);
			rd = rdat;
			req <= 1'b0;
			sel <= 4'h0;
			@(posedge clk_i);
		end
	endtask
	task rchk(input [7:0] a, input [31:0] e);
		begin
			wb(1'b0, a, 32'h0);
			chk(rd, e);
		end
	endtask
	task pulse(input [7:0] t, input [7:0] n);
		begin
			trap <= t;
			nreq <= n;
			@(posedge clk_i);
			trap <= 8'h00;
			nreq <= 8'h00;
		end
	endtask
	// Waits for the edge at which the CPU takes an offer.
	task grab(input [23:0] ea, input [6:0] en);
		begin
			@(posedge clk_i);
			while (!(valid === 1'b1 && vack === 1'b1))
				@(posedge clk_i);
			chk(vaddr, ea);
			chk(vnum, en);
			chk(is_trap, en < 7'h10);
		end
	endtask
	// Clock and hang guard.
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cycles = cycles + 1;
		if (cycles == 3000)
		begin
			mismatches = mismatches + 1;
			end_sim;
		end
	end
	// Main sequence of bus and vector scenarios.
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(8'h04, 32'h0);
		rchk(8'h0C, 32'h0);
		rchk(8'h1C, 32'h0);
		wb(1'b1, 8'h00, 32'h5A);
		rchk(8'h00, 32'h5A);
		wsel = 4'h0;
		wb(1'b1, 8'h00, 32'h33);
		wsel = 4'hF;
		rchk(8'h00, 32'h5A);
		pulse(8'h01, 8'h00);
		grab({8'h5A, 16'h0002 << 2}, 7'h02);
		@(posedge clk_i);
		chk(allow, 1'b0);
		pulse(8'h02, 8'h00);
		wb(1'b1, 8'h3C, 32'hC5);
		chk(valid, 1'b0);
		rchk(8'h08, 32'h03);
		chk(irq, 1'b0);
		svc <= 8'h01;
		grab({8'h5A, 16'h0004 << 2}, 7'h04);
		grab({8'h5A, 16'h004C << 2}, 7'h4C);
		svc <= 8'h00;
		dly <= 4'h0;
		rchk(8'h08, 32'h03);
		wb(1'b1, 8'h04, 32'h01);
		wb(1'b1, 8'h20, 32'hC5);
		chk(valid, 1'b0);
		wb(1'b1, 8'h20, 32'h46);
		chk(valid, 1'b0);
		pulse(8'h00, 8'h01);
		grab({8'h5A, 16'h0010 << 3}, 7'h10);
		wb(1'b1, 8'h0C, 32'h02);
		chk(irq, 1'b1);
		wb(1'b1, 8'h08, 32'h02);
		chk(irq, 1'b0);
		rchk(8'h08, 32'h01);
		pulse(8'h02, 8'h00);
		grab({8'h5A, 16'h0004 << 3}, 7'h04);
		chk(irq, 1'b1);
		pulse(8'h01, 8'h00);
		grab({8'h5A, 16'h0002 << 3}, 7'h02);
		chk(allow, 1'b0);
		end_sim;
	end
endmodule
